// file: dv/sacc_analog_model.sv
// behavioural analog front end: channel levels and comparator
`timescale 1ns/1ps
module sacc_analog_model
(
   input  wire logic [2:0] chan,
   input  wire logic [7:0] connect,
   input  wire logic       power,
   input  wire logic [9:0] trial,
   input  wire logic [9:0] level [8],
   output logic            above
);
   // a pin reaches the comparator only while routed and powered
   assign above = power && connect[chan] && (level[chan] >= trial);
endmodule

// file: dv/sacc_control_props.sv
// concurrent checks on the converter control ports
`timescale 1ns/1ps
module sacc_control_props
   import sacc_pkg::*;
(
   input wire logic       CLOCK,
   input wire logic       RESET,
   input wire logic [7:0] SFR_ADDR,
   input wire logic [7:0] SFR_WDATA,
   input wire logic       SFR_WR,
   input wire logic       SFR_RD,
   input wire logic [7:0] SFR_RDATA,
   input wire logic       IRQ,
   input wire logic [7:0] PORT_ALT_FUNCTION_SELECT,
   input wire logic [7:0] PORT_ALT_CHOICE_SELECT,
   input wire logic [7:0] ANALOG_PIN_CONNECT,
   input wire logic [2:0] ANALOG_CHANNEL,
   input wire logic       CONV_POWER_ON,
   input wire logic       CONV_REFERENCE_CLOCK
);
   // ----------------------------------------------------------------
   // shadow of prescale and enable fields, settle count after writes
   // ----------------------------------------------------------------
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (RESET);
   logic [2:0] cnt_ff;
   logic [2:0] code_ff;
   logic       gate_ff;
   logic       en_ff;
   wire        wp = SFR_WR && SFR_ADDR == 8'h94;
   wire        wc = SFR_WR && SFR_ADDR == 8'h97;
   wire        settled = cnt_ff >= 3'h4;
   // track writes so divider checks wait for the clock to settle
   always_ff @(posedge CLOCK or posedge RESET)
   begin
      if (RESET)
      begin
         cnt_ff  <= 3'h0;
         code_ff <= 3'h0;
         gate_ff <= 1'b0;
         en_ff   <= 1'b0;
      end
      else
      begin
         cnt_ff  <= (wp || wc) ? 3'h0 : (cnt_ff == 3'h7 ? cnt_ff : cnt_ff + 3'h1);
         code_ff <= wp ? SFR_WDATA[2:0] : code_ff;
         gate_ff <= wp ? SFR_WDATA[3] : gate_ff;
         en_ff   <= wc ? SFR_WDATA[6] : en_ff;
      end
   end
   property p_chan; wc |=> ANALOG_CHANNEL == $past(SFR_WDATA[4:2]); endproperty
   a_chan: assert property (p_chan) else $error("channel not taken");
   property p_pwr; wc |=> CONV_POWER_ON == $past(SFR_WDATA[5]); endproperty
   a_pwr: assert property (p_pwr) else $error("power enable wrong");
   property p_high; SFR_RD && SFR_ADDR == 8'h96 |=> SFR_RDATA[7:2] == 6'h00; endproperty
   a_high: assert property (p_high) else $error("result high reserved set");
   property p_pin; $onehot0(ANALOG_PIN_CONNECT) && (ANALOG_PIN_CONNECT &
      ~(PORT_ALT_FUNCTION_SELECT & PORT_ALT_CHOICE_SELECT)) == 8'h00; endproperty
   a_pin: assert property (p_pin) else $error("pin routed wrongly");
   property p_gate; !gate_ff && settled |-> $stable(CONV_REFERENCE_CLOCK); endproperty
   a_gate: assert property (p_gate) else $error("clock runs while gated");
   property p_div1; gate_ff && CONV_POWER_ON && code_ff inside {3'h0, 3'h1} && settled |->
      $changed(CONV_REFERENCE_CLOCK); endproperty
   a_div1: assert property (p_div1) else $error("fast divide wrong");
   property p_divn; gate_ff && CONV_POWER_ON && code_ff >= 3'h2 && settled &&
      $changed(CONV_REFERENCE_CLOCK) |=> $stable(CONV_REFERENCE_CLOCK); endproperty
   a_divn: assert property (p_divn) else $error("slow divide too fast");
   property p_irq_en; IRQ |-> en_ff; endproperty
   a_irq_en: assert property (p_irq_en) else $error("irq while disabled");
   property p_irq_hold; IRQ && !wc |=> IRQ; endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("irq flag lost");
   // start reads back as 1 only on a read taken right after a start write
   property p_start; SFR_RD && SFR_ADDR == 8'h97 |=> !SFR_RDATA[1] ||
      ($past(wc, 2) && $past(SFR_WDATA[1], 2)); endproperty
   a_start: assert property (p_start) else $error("start bit not self cleared");
   c_irq: cover property ($rose(IRQ));
   c_div4: cover property (gate_ff && code_ff == 3'h2 && settled);
   c_res: cover property (SFR_RD && SFR_ADDR == 8'h95);
endmodule
bind sacc_control sacc_control_props u_sacc_control_props (.CLOCK(CLOCK), .RESET(RESET),
   .SFR_ADDR(SFR_ADDR), .SFR_WDATA(SFR_WDATA), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD),
   .SFR_RDATA(SFR_RDATA), .IRQ(IRQ), .PORT_ALT_FUNCTION_SELECT(PORT_ALT_FUNCTION_SELECT),
   .PORT_ALT_CHOICE_SELECT(PORT_ALT_CHOICE_SELECT), .ANALOG_PIN_CONNECT(ANALOG_PIN_CONNECT),
   .ANALOG_CHANNEL(ANALOG_CHANNEL), .CONV_POWER_ON(CONV_POWER_ON),
   .CONV_REFERENCE_CLOCK(CONV_REFERENCE_CLOCK));

// file: dv/tb_top.sv
// self-checking bench for the converter control
`timescale 1ns/1ps
module tb_top;
   // ----------------------------------------------------------------
   // stimulus, design, analog model and checks
   // ----------------------------------------------------------------
   logic       CLOCK = 1'b0;
   logic       RESET = 1'b1;
   logic [7:0] SFR_ADDR = 8'h00;
   logic [7:0] SFR_WDATA = 8'h00;
   logic       SFR_WR = 1'b0;
   logic       SFR_RD = 1'b0;
   logic [7:0] PFS = 8'hFF;
   logic [7:0] PCS = 8'hFF;
   logic [7:0] SFR_RDATA, ANALOG_PIN_CONNECT, rdata_seen, cv;
   logic [2:0] ANALOG_CHANNEL;
   logic [9:0] DAC_TRIAL;
   logic       IRQ, CONV_POWER_ON, CONV_REFERENCE_CLOCK, above;
   logic [9:0] level [8] = '{10'h000, 10'h3FF, 10'h155, 10'h2AA,
                             10'h001, 10'h200, 10'h1FF, 10'h37C};
   int         failures = 0;
   int         checks_done = 0;
   int         cycles = 0;
   int         t0 = 0;
   int         lo = 0;
   always #2.5 CLOCK = ~CLOCK;
   sacc_control u_sacc_control (.CLOCK(CLOCK), .RESET(RESET), .SFR_ADDR(SFR_ADDR),
      .SFR_WDATA(SFR_WDATA), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD), .SFR_RDATA(SFR_RDATA),
      .IRQ(IRQ), .PORT_ALT_FUNCTION_SELECT(PFS), .PORT_ALT_CHOICE_SELECT(PCS),
      .ANALOG_PIN_CONNECT(ANALOG_PIN_CONNECT), .ANALOG_CHANNEL(ANALOG_CHANNEL),
      .CONV_POWER_ON(CONV_POWER_ON), .CONV_REFERENCE_CLOCK(CONV_REFERENCE_CLOCK),
      .DAC_TRIAL(DAC_TRIAL), .COMPARATOR_ABOVE(above));
   sacc_analog_model u_sacc_analog_model (.chan(ANALOG_CHANNEL),
      .connect(ANALOG_PIN_CONNECT), .power(CONV_POWER_ON), .trial(DAC_TRIAL),
      .level(level), .above(above));
   // compare and count
   task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
      checks_done++;
      if (got !== exp)
      begin
         failures++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one register write, strobe high for one edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge CLOCK);
      SFR_ADDR <= a;
      SFR_WDATA <= d;
      SFR_WR <= 1'b1;
      @(posedge CLOCK);
      SFR_WR <= 1'b0;
   endtask
   // one register read, data taken the cycle after the strobe
   task automatic rd(input logic [7:0] a);
      @(posedge CLOCK);
      SFR_ADDR <= a;
      SFR_RD <= 1'b1;
      @(posedge CLOCK);
      SFR_RD <= 1'b0;
      #1 rdata_seen = SFR_RDATA;
   endtask
   // bounded wait for the interrupt request
   task automatic wait_irq();
      for (int i = 0; i < 400 && IRQ !== 1'b1; i++)
         @(posedge CLOCK) #1;
   endtask
   task automatic finish_test();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // cycle ceiling against a hang
   always @(posedge CLOCK)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         failures++;
         finish_test();
      end
   end
   // main sequence
   initial
   begin
      repeat (10) @(posedge CLOCK);
      RESET <= 1'b0;
      for (int a = 8'h93; a <= 8'h97; a++)
      begin
         rd(a[7:0]);
         chk("reset read", 10'h000, {2'b00, rdata_seen});
      end
      $display("test reset done");
      for (int ch = 0; ch < 8; ch++)
      begin
         wr(8'h94, 8'h08 | 8'(ch % 3));
         rd(8'h94);
         chk("prescale", 10'(8'h08 | 8'(ch % 3)), {2'b00, rdata_seen});
         cv = {1'b0, ch != 7, 1'b1, 3'(ch), 2'b00};
         wr(8'h97, cv);
         repeat (4) @(posedge CLOCK);
         wr(8'h97, cv | 8'h02);
         t0 = cycles;
         rd(8'h97);
         chk("busy done", {2'b00, cv}, {2'b00, rdata_seen & 8'hFD});
         wait_irq();
         chk("irq", 10'(ch != 7), 10'(IRQ));
         // about 32 converter clocks per conversion, a few cycles of hand-over on top
         t0 = cycles - t0;
         lo = 32 << (ch % 3);
         if (ch != 7)
            chk("conv time", 10'h001, 10'(t0 >= lo && t0 <= lo + 8));
         rd(8'h97);
         chk("ctrl done", {2'b00, cv | 8'h81}, {2'b00, rdata_seen});
         rd(8'h95);
         chk("result low", {2'b00, level[ch][7:0]}, {2'b00, rdata_seen});
         rd(8'h96);
         chk("result high", 10'(level[ch][9:8]), {2'b00, rdata_seen});
         chk("connect", 10'(8'h01 << ch), {2'b00, ANALOG_PIN_CONNECT});
         wr(8'h97, cv & 8'h7E);
         #1 chk("irq clear", 10'h000, 10'(IRQ));
      end
      $display("test conversions done");
      wr(8'h97, 8'h02);
      repeat (200) @(posedge CLOCK);
      rd(8'h97);
      chk("start unpowered", 10'h000, {2'b00, rdata_seen});
      wr(8'h94, 8'h00);
      wr(8'h97, 8'h20);
      repeat (4) @(posedge CLOCK);
      wr(8'h97, 8'h22);
      repeat (200) @(posedge CLOCK);
      rd(8'h97);
      chk("gated done", 10'h000, {2'b00, rdata_seen & 8'h81});
      @(posedge CLOCK);
      PFS <= 8'h00;
      @(posedge CLOCK) #1;
      chk("gpio connect", 10'h000, {2'b00, ANALOG_PIN_CONNECT});
      $display("test refusals done");
      finish_test();
   end
endmodule

// file: rtl/sacc_control.sv
// converter control and result registers with clock prescaler and pin routing
// Summary of operation
// RULE_01 - three channel bits route input 0 through 7 to the converter
// RULE_02 - low eight result bits in low register, top two in high bits 1:0
// RULE_03 - writing start begins a conversion; start clears itself next cycle
// RULE_04 - done status is 0 during conversion, 1 at completion, software clearable
// RULE_05 - result registers load when the conversion completes
// RULE_06 - interrupt flag sets on done rising; only software clears it
// RULE_07 - interrupt request only while flag and enable are both 1
// RULE_08 - power enable 0 keeps the converter off; 1 powers it up
// RULE_09 - software waits the calibration time after enabling before starting
// RULE_10 - prescale bit 3 gates the converter clock, off at reset
// RULE_11 - converter clock is oscillator divided by 1, 2 or 4
// RULE_12 - software keeps converter clock between 2 and 16 MHz
// RULE_13 - conversion takes about 4 us at 8 MHz, scaling with period
// RULE_14 - pin is general purpose when its function select bit is 0
// RULE_15 - pin reaches converter only when choice select bit is also 1
// RULE_16 - result resolved msb first, one bit per converter clock, held until next
// RULE_17 - start and completion pass between rates without loss or doubling
`timescale 1ns/1ps
module sacc_control
   import sacc_pkg::*;
(
   input  wire logic       CLOCK,
   input  wire logic       RESET,
   input  wire logic [7:0] SFR_ADDR,
   input  wire logic [7:0] SFR_WDATA,
   input  wire logic       SFR_WR,
   input  wire logic       SFR_RD,
   output logic [7:0]      SFR_RDATA,
   output logic            IRQ,
   input  wire logic [7:0] PORT_ALT_FUNCTION_SELECT,
   input  wire logic [7:0] PORT_ALT_CHOICE_SELECT,
   output logic [7:0]      ANALOG_PIN_CONNECT,
   output logic [2:0]      ANALOG_CHANNEL,
   output logic            CONV_POWER_ON,
   output logic            CONV_REFERENCE_CLOCK,
   output logic [9:0]      DAC_TRIAL,
   input  wire logic       COMPARATOR_ABOVE
);
`include "sacc_defs.svh"

   //---------------------------------------------------------------
   // registers
   //---------------------------------------------------------------
   logic [3:0]  prescale_ff;
   logic        irq_flag_ff;
   logic        irq_en_ff;
   logic        pwr_en_ff;
   logic [2:0]  chan_ff;
   logic        start_ff;
   logic        done_stat_ff;
   logic        done_d_ff;
   logic [9:0]  result_ff;
   logic [1:0]  div_cnt_ff;
   logic        tick_ff;
   logic        refclk_ff;
   logic        start_pend_ff;
   logic        nxt_tick;
   logic        wr_ctrl;
   logic        eng_busy;
   logic        eng_done;
   logic [9:0]  eng_trial;

   assign wr_ctrl = SFR_WR && (SFR_ADDR == `SACC_OFS_CTRL);

   // decode of the divider field, codes 3'h3 to 3'h7 treated as divide by four
   function automatic sacc_div_t div_of(input logic [2:0] code);
      unique case (code)
         3'h0:    div_of = SACC_DIV1;
         3'h1:    div_of = SACC_DIV2;
         3'h2:    div_of = SACC_DIV4;
         default: div_of = SACC_DIVX;
      endcase
   endfunction

   //---------------------------------------------------------------
   // register writes
   //---------------------------------------------------------------
   // prescale register keeps gate and divider bits only
   always_ff @(posedge CLOCK or posedge RESET)
   begin
      if (RESET)
         prescale_ff <= 4'(`SACC_RST_PRESCALE);
      else if (SFR_WR && SFR_ADDR == `SACC_OFS_PRESCALE)
         prescale_ff <= SFR_WDATA[3:0];
   end

   // control fields written by software
   always_ff @(posedge CLOCK or posedge RESET)
   begin
      if (RESET)
      begin
         irq_en_ff <= 1'b0;
         pwr_en_ff <= 1'b0;
         chan_ff   <= 3'h0;
      end
      else if (wr_ctrl)
      begin
         irq_en_ff <= SFR_WDATA[`SACC_BIT_IRQ_EN];
         pwr_en_ff <= SFR_WDATA[`SACC_BIT_PWR_EN];
         chan_ff   <= SFR_WDATA[`SACC_BIT_CHAN_HI:`SACC_BIT_CHAN_LO];
      end
   end

   // start bit reads 1 for one cycle after the write
   always_ff @(posedge CLOCK or posedge RESET)
   begin
      if (RESET)
         start_ff <= 1'b0;
      else
         start_ff <= wr_ctrl && SFR_WDATA[`SACC_BIT_START]; // RULE_03
   end

   // start request held until the engine takes it on a converter tick
   always_ff @(posedge CLOCK or posedge RESET)
   begin
      if (RESET)
         start_pend_ff <= 1'b0;
      else if (wr_ctrl && SFR_WDATA[`SACC_BIT_START] && pwr_en_ff) // RULE_08
         start_pend_ff <= 1'b1; // RULE_03
      // only an idle engine takes the request, so a start during a conversion waits its turn
      else if ((tick_ff && !eng_busy) || !pwr_en_ff)
         start_pend_ff <= 1'b0; // RULE_17
   end

   //---------------------------------------------------------------
   // converter clock divider and gate
   //---------------------------------------------------------------
   always_comb
   begin
      nxt_tick = 1'b0;
      if (prescale_ff[`SACC_BIT_CLK_GATE]) // RULE_10
         unique case (div_of(prescale_ff[2:0])) // RULE_11
            SACC_DIV1: nxt_tick = 1'b1;
            SACC_DIV2: nxt_tick = (div_cnt_ff[0] == 1'b1);
            SACC_DIV4: nxt_tick = (div_cnt_ff == 2'h3);
            SACC_DIVX: nxt_tick = (div_cnt_ff == 2'h3);
         endcase
   end

   // divider count and tick, the tick is the converter clock enable
   always_ff @(posedge CLOCK or posedge RESET)
   begin
      if (RESET)
      begin
         div_cnt_ff <= 2'h0;
         tick_ff    <= 1'b0;
         refclk_ff  <= 1'b0;
      end
      else
      begin
         div_cnt_ff <= div_cnt_ff + 2'h1;
         tick_ff    <= nxt_tick && pwr_en_ff;
         refclk_ff  <= prescale_ff[`SACC_BIT_CLK_GATE] && pwr_en_ff
                       && (prescale_ff[2:0] == 3'h0 ? !refclk_ff
                           : (prescale_ff[2:0] == 3'h1 ? div_cnt_ff[0] : div_cnt_ff[1]));
      end
   end

   //---------------------------------------------------------------
   // engine
   //---------------------------------------------------------------
   sacc_sar_engine u_engine
   (
      .clock     (CLOCK),
      .reset     (RESET || !pwr_en_ff),
      .tick      (tick_ff),
      .go        (start_pend_ff && tick_ff), // RULE_17
      .cmp_above (COMPARATOR_ABOVE),
      .trial     (eng_trial),
      .busy      (eng_busy),
      .done      (eng_done)
   );

   //---------------------------------------------------------------
   // status, result and interrupt
   //---------------------------------------------------------------
   // done status: set at completion wins over clear, dropped while busy
   always_ff @(posedge CLOCK or posedge RESET)
   begin
      if (RESET)
         done_stat_ff <= 1'b0;
      else if (eng_done)
         done_stat_ff <= 1'b1; // RULE_04
      else if (eng_busy || start_pend_ff)
         done_stat_ff <= 1'b0; // RULE_04
      else if (wr_ctrl && !SFR_WDATA[`SACC_BIT_DONE])
         done_stat_ff <= 1'b0; // RULE_04
   end

   // result capture at completion, held otherwise
   always_ff @(posedge CLOCK or posedge RESET)
   begin
      if (RESET)
         result_ff <= 10'h000;
      else if (eng_done)
         result_ff <= eng_trial; // RULE_05
   end

   // interrupt flag on rising done; set wins over software clear
   always_ff @(posedge CLOCK or posedge RESET)
   begin
      if (RESET)
      begin
         done_d_ff   <= 1'b0;
         irq_flag_ff <= 1'b0;
      end
      else
      begin
         done_d_ff <= done_stat_ff;
         if (done_stat_ff && !done_d_ff)
            irq_flag_ff <= 1'b1; // RULE_06
         else if (wr_ctrl && !SFR_WDATA[`SACC_BIT_IRQ_FLAG])
            irq_flag_ff <= 1'b0; // RULE_06
      end
   end

   assign IRQ = irq_flag_ff && irq_en_ff; // RULE_07

   //---------------------------------------------------------------
   // analog side
   //---------------------------------------------------------------
   assign ANALOG_CHANNEL       = chan_ff; // RULE_01
   assign CONV_POWER_ON        = pwr_en_ff; // RULE_08
   assign CONV_REFERENCE_CLOCK = refclk_ff; // RULE_10
   assign DAC_TRIAL            = eng_trial; // RULE_16

   // pin connects to the multiplexer when both selects are set and it is the channel
   genvar g;
   generate
      for (g = 0; g < 8; g++)
      begin : g_pin
         assign ANALOG_PIN_CONNECT[g] = PORT_ALT_FUNCTION_SELECT[g] // RULE_14
                                        && PORT_ALT_CHOICE_SELECT[g] // RULE_15
                                        && (chan_ff == 3'(g)); // RULE_01
      end
   endgenerate

   //---------------------------------------------------------------
   // read mux
   //---------------------------------------------------------------
   always_ff @(posedge CLOCK or posedge RESET)
   begin
      if (RESET)
         SFR_RDATA <= 8'h00;
      else if (SFR_RD)
         unique case (SFR_ADDR)
            `SACC_OFS_PRESCALE: SFR_RDATA <= {4'h0, prescale_ff};
            `SACC_OFS_RES_LOW:  SFR_RDATA <= result_ff[7:0]; // RULE_02
            `SACC_OFS_RES_HIGH: SFR_RDATA <= {6'h00, result_ff[9:8]}; // RULE_02
            `SACC_OFS_CTRL:     SFR_RDATA <= {irq_flag_ff, irq_en_ff, pwr_en_ff, chan_ff,
                                              start_ff, done_stat_ff};
            default:            SFR_RDATA <= 8'h00;
         endcase
   end
endmodule

// file: rtl/sacc_defs.svh
// register offsets, field positions, reset values and timing counts of the converter control
`ifndef SACC_DEFS_SVH
`define SACC_DEFS_SVH
`define SACC_OFS_PRESCALE   8'h94
`define SACC_OFS_RES_LOW    8'h95
`define SACC_OFS_RES_HIGH   8'h96
`define SACC_OFS_CTRL       8'h97
`define SACC_RST_PRESCALE   8'h00
`define SACC_RST_CTRL       8'h00
`define SACC_BIT_IRQ_FLAG   7
`define SACC_BIT_IRQ_EN     6
`define SACC_BIT_PWR_EN     5
`define SACC_BIT_CHAN_HI    4
`define SACC_BIT_CHAN_LO    2
`define SACC_BIT_START      1
`define SACC_BIT_DONE       0
`define SACC_BIT_CLK_GATE   3
`define SACC_RES_BITS       10
`define SACC_CONV_NS        4000
`define SACC_CONV_MHZ       8
`define SACC_CONV_CLKS      ((`SACC_CONV_NS * `SACC_CONV_MHZ) / 1000)
`define SACC_CAL_MS         16
`endif

// file: rtl/sacc_pkg.sv
// types shared by the converter control files
package sacc_pkg;
   typedef enum logic [1:0] {SACC_DIV1, SACC_DIV2, SACC_DIV4, SACC_DIVX} sacc_div_t;
   typedef enum logic [1:0] {SACC_IDLE, SACC_SETTLE, SACC_RESOLVE, SACC_FINISH} sacc_state_t;
endpackage

// file: rtl/sacc_sar_engine.sv
// successive-approximation engine running on converter clock ticks
`timescale 1ns/1ps
module sacc_sar_engine
   import sacc_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       reset,
   input  wire logic       tick,
   input  wire logic       go,
   input  wire logic       cmp_above,
   output logic [9:0]      trial,
   output logic            busy,
   output logic            done
);
`include "sacc_defs.svh"

   sacc_state_t state_ff;
   logic [9:0]  sar_ff;
   logic [3:0]  bit_ff;
   logic [5:0]  wait_ff;
   logic        done_ff;

   assign trial = sar_ff;
   assign busy  = (state_ff != SACC_IDLE);
   assign done  = done_ff;

   // settle for the rest of the conversion time, then one bit per tick from msb down
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         state_ff <= SACC_IDLE;
         sar_ff   <= 10'h000;
         bit_ff   <= 4'h0;
         wait_ff  <= 6'h00;
         done_ff  <= 1'b0;
      end
      else
      begin
         done_ff <= 1'b0;
         unique case (state_ff)
            SACC_IDLE:
               if (go)
               begin
                  state_ff <= SACC_SETTLE;
                  wait_ff  <= 6'(`SACC_CONV_CLKS - `SACC_RES_BITS - 1); // RULE_13
                  sar_ff   <= 10'h200;
                  bit_ff   <= 4'h9;
               end
            SACC_SETTLE:
               if (tick)
               begin
                  if (wait_ff == 6'h00)
                     state_ff <= SACC_RESOLVE;
                  else
                     wait_ff <= wait_ff - 6'h01;
               end
            SACC_RESOLVE:
               if (tick)
               begin
                  // keep the trial bit unless the input sits below it, then try the next one
                  if (!cmp_above)
                     sar_ff[bit_ff] <= 1'b0; // RULE_16
                  if (bit_ff == 4'h0)
                     state_ff <= SACC_FINISH;
                  else
                  begin
                     bit_ff <= bit_ff - 4'h1;
                     sar_ff[bit_ff - 4'h1] <= 1'b1;
                  end
               end
            SACC_FINISH:
            begin
               done_ff  <= 1'b1;
               state_ff <= SACC_IDLE;
            end
         endcase
      end
   end
endmodule
